// ==== core/button_debounce.sv ====
// Debouncer for one front-panel button.
`timescale 1ns/10ps
module button_debounce #(
  parameter int CYCLES = 500000
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Raw and settled button level.
  input wire logic raw,
  output logic clean_q
);

  localparam int CW = $clog2(CYCLES + 1);

  // A zero settle time cannot be counted.
  if (CYCLES < 1) begin : g_bad_cycles
    $error("button_debounce: CYCLES must be at least 1");
  end

  logic [CW-1:0] cnt_q;
  wire differs = (raw != clean_q);
  wire settled = (cnt_q == CW'(CYCLES - 1));

  // The level must differ for CYCLES cycles in a row before it is taken.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      clean_q <= 1'b0;
    end else if (!differs || settled) begin
      cnt_q <= '0;
      clean_q <= clean_q ^ differs;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

endmodule : button_debounce

// ==== core/dc_servo_position_loop.sv ====
// Closed-loop position controller for a brushed DC motor.
// What this block does
// - Adds proportional gain (0..32767) times position error to drive.
// - Integrates position error, weighted by integral gain 0..32767.
// - Adds derivative gain times the change of position error.
// - Clamps the integral accumulator magnitude to a limit 0..32767.
// - In jog mode a button press starts a jog of the stored step at the jog_vel speed.
// - In go-to mode each button has its own stored target position.
// - In go-to mode the top button moves to the top target.
// - In go-to mode the bottom button moves to the bottom target.
// - Both buttons held together for 2 s start homing, in any mode.
// - Retained settings load into the working set after power-up.
// - Limit switches stop travel and serve as the homing reference.
// - Each limit switch has a configurable active level.
// - Encoder channels decode as quadrature for position and direction.
// - The filter uses 16-bit error and gain arithmetic.
// - Drive is 8-bit sign and magnitude PWM.
// - Each limit switch closes, opens on contact, or is ignored.
`timescale 1ns/10ps
`include "servo_map.svh"
module dc_servo_position_loop import servo_pkg::*; #(
  parameter int HOLD_CYCLES = `HOLD_CYCLES,
  parameter int DEB_CYCLES = `DEB_CYCLES,
  parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Encoder and limit switches.
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic fwd_lim_in,
  input wire logic rev_lim_in,
  // Front-panel buttons.
  input wire logic btn_top,
  input wire logic btn_bot,
  // Limit and motion settings, used as they stand.
  input wire lim_cfg_e fwd_lim_cfg,
  input wire lim_cfg_e rev_lim_cfg,
  input wire logic fwd_lim_pol,
  input wire logic rev_lim_pol,
  input wire logic home_fwd,
  input wire logic [15:0] home_vel,
  input wire logic [15:0] jog_vel,
  input wire logic [15:0] move_vel,
  // Retained settings, loaded after power-up.
  input wire logic [14:0] nv_kp,
  input wire logic [14:0] nv_ki,
  input wire logic [14:0] nv_kd,
  input wire logic [14:0] nv_ilim,
  input wire btn_mode_e nv_mode,
  input wire logic [31:0] nv_top_pos,
  input wire logic [31:0] nv_bot_pos,
  input wire logic [31:0] nv_jog_step,
  // Host settings, loaded on a one-cycle strobe.
  input wire logic host_load,
  input wire logic [14:0] host_kp,
  input wire logic [14:0] host_ki,
  input wire logic [14:0] host_kd,
  input wire logic [14:0] host_ilim,
  input wire btn_mode_e host_mode,
  input wire logic [31:0] host_top_pos,
  input wire logic [31:0] host_bot_pos,
  input wire logic [31:0] host_jog_step,
  // Motor drive and status.
  output logic motor_pwm,
  output logic motor_rev,
  output logic [31:0] position,
  output logic fwd_limit,
  output logic rev_limit,
  output logic busy,
  output logic homed
);

  // Counts that the logic cannot serve are refused at elaboration.
  if (HOLD_CYCLES < 1 || DEB_CYCLES < 1 || SAMPLE_CYCLES < 3) begin : g_bad
    $error("dc_servo_position_loop: count parameter out of range");
  end

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int SW = $clog2(SAMPLE_CYCLES + 1);

  // Working configuration.
  logic [14:0] kp_q, ki_q, kd_q, ilim_q;
  btn_mode_e mode_q;
  logic [31:0] top_q, bot_q, jstep_q;
  motion_e st_q;

  // Settings come from the retained set once after reset, and from the
  // host whenever it strobes after the boot cycle, so a host overrides whatever was retained.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      kp_q <= `GAIN_RESET;
      ki_q <= `GAIN_RESET;
      kd_q <= `GAIN_RESET;
      ilim_q <= `GAIN_RESET;
      mode_q <= MODE_JOG;
      top_q <= 32'h0;
      bot_q <= 32'h0;
      jstep_q <= 32'h0;
    end else if (st_q == ST_BOOT) begin
      kp_q <= nv_kp;
      ki_q <= nv_ki;
      kd_q <= nv_kd;
      ilim_q <= nv_ilim;
      mode_q <= nv_mode;
      top_q <= nv_top_pos;
      bot_q <= nv_bot_pos;
      jstep_q <= nv_jog_step;
    end else if (host_load) begin
      kp_q <= host_kp;
      ki_q <= host_ki;
      kd_q <= host_kd;
      ilim_q <= host_ilim;
      mode_q <= host_mode;
      top_q <= host_top_pos;
      bot_q <= host_bot_pos;
      jstep_q <= host_jog_step;
    end
  end

  // Limit decode: polarity first, then the contact sense, then ignore.
  wire fwd_lvl = (fwd_lim_in == fwd_lim_pol) ^ (fwd_lim_cfg == LIM_BREAKS);
  wire rev_lvl = (rev_lim_in == rev_lim_pol) ^ (rev_lim_cfg == LIM_BREAKS);
  wire fwd_act = fwd_lvl && (fwd_lim_cfg != LIM_IGNORE);
  wire rev_act = rev_lvl && (rev_lim_cfg != LIM_IGNORE);

  // Quadrature decode: one step when exactly one channel changed.
  logic pa_q, pb_q;
  logic signed [31:0] pos_q;
  wire q_step = (enc_a ^ pa_q) ^ (enc_b ^ pb_q);
  wire q_up = pa_q ^ enc_b;
  wire home_hit = (st_q == ST_HOME) && (home_fwd ? fwd_act : rev_act);

  // The counter zeroes at the home switch while homing; otherwise it follows the encoder.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      pos_q <= 32'sh0;
    end else begin
      pa_q <= enc_a;
      pb_q <= enc_b;
      if (home_hit) pos_q <= 32'sh0;
      else if (q_step && q_up) pos_q <= pos_q + 32'sh1;
      else if (q_step) pos_q <= pos_q - 32'sh1;
    end
  end

  // Debounced buttons.
  logic top_c, bot_c, top_p_q, bot_p_q;
  button_debounce #(.CYCLES(DEB_CYCLES)) u_deb_top (
    .ref_clk(ref_clk), .rst(rst), .raw(btn_top), .clean_q(top_c));
  button_debounce #(.CYCLES(DEB_CYCLES)) u_deb_bot (
    .ref_clk(ref_clk), .rst(rst), .raw(btn_bot), .clean_q(bot_c));

  // A press counts only while the other button is up.
  wire top_press = top_c && !top_p_q && !bot_c;
  wire bot_press = bot_c && !bot_p_q && !top_c;
  wire both = top_c && bot_c;

  // Hold timer: runs while both are down, restarts on any release.
  logic [HW-1:0] hold_q;
  logic hold_done_q;
  wire hold_hit = both && !hold_done_q && (hold_q == HW'(HOLD_CYCLES - 1));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_q <= '0;
      hold_done_q <= 1'b0;
      top_p_q <= 1'b0;
      bot_p_q <= 1'b0;
    end else begin
      top_p_q <= top_c;
      bot_p_q <= bot_c;
      hold_done_q <= both && (hold_done_q || hold_hit);
      if (!both || hold_hit) hold_q <= '0;
      else if (!hold_done_q) hold_q <= hold_q + HW'(1);
    end
  end

  // Sample tick for the profile and the filter.
  logic [SW-1:0] smp_q;
  wire tick = (smp_q == SW'(SAMPLE_CYCLES - 1));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) smp_q <= '0;
    else smp_q <= tick ? '0 : smp_q + SW'(1);
  end

  // Motion profile: the command walks toward the goal by vel each tick.
  logic signed [31:0] cmd_q, goal_q;
  logic [15:0] vel_q;
  logic homed_q;
  wire signed [32:0] gap = {goal_q[31], goal_q} - {cmd_q[31], cmd_q};
  wire gap_neg = gap[32];
  wire [32:0] gap_mag = gap_neg ? 33'(-gap) : 33'(gap);
  wire arrive = (gap_mag <= {17'h0, vel_q});
  wire signed [31:0] vel_s = $signed({16'h0, vel_q});
  wire stop_fwd = fwd_act && !gap_neg;
  wire stop_rev = rev_act && gap_neg;
  wire can_cmd = (st_q == ST_IDLE) || (st_q == ST_MOVE);
  wire signed [31:0] jog_goal = top_press ? cmd_q + $signed(jstep_q)
                                          : cmd_q - $signed(jstep_q);
  wire signed [31:0] preset = top_press ? $signed(top_q) : $signed(bot_q);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_BOOT;
      cmd_q <= 32'sh0;
      goal_q <= 32'sh0;
      vel_q <= 16'h0;
      homed_q <= 1'b0;
    end else begin
      case (st_q)
        ST_BOOT: begin
          st_q <= ST_IDLE;
        end
        ST_IDLE, ST_MOVE: begin
          if (hold_hit) begin
            st_q <= ST_HOME;
            vel_q <= home_vel;
            homed_q <= 1'b0;
          end else if ((top_press || bot_press) && mode_q == MODE_JOG) begin
            st_q <= ST_MOVE;
            goal_q <= jog_goal;
            vel_q <= jog_vel;
          end else if (top_press || bot_press) begin
            st_q <= ST_MOVE;
            goal_q <= preset;
            vel_q <= move_vel;
          end else if (st_q == ST_MOVE && (stop_fwd || stop_rev)) begin
            st_q <= ST_IDLE;
            goal_q <= pos_q;
            cmd_q <= pos_q;
          end else if (st_q == ST_MOVE && tick) begin
            if (arrive) begin
              cmd_q <= goal_q;
              st_q <= ST_IDLE;
            end else begin
              cmd_q <= gap_neg ? cmd_q - vel_s : cmd_q + vel_s;
            end
          end
        end
        ST_HOME: begin
          if (home_hit) begin
            st_q <= ST_IDLE;
            cmd_q <= 32'sh0;
            goal_q <= 32'sh0;
            homed_q <= 1'b1;
          end else if (tick) begin
            cmd_q <= home_fwd ? cmd_q + vel_s : cmd_q - vel_s;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Position error, saturated to 16 bits so the filter never sees a wrap.
  wire signed [32:0] err_w = {cmd_q[31], cmd_q} - {pos_q[31], pos_q};
  wire signed [15:0] err_sat = (err_w > 33'sh7fff) ? $signed(`ERR_MAX) :
                               (err_w < -33'sh7fff) ? -$signed(`ERR_MAX) :
                               err_w[15:0];

  // Filter terms; every gain is a 15-bit positive number.
  logic signed [15:0] e_q, e_prev_q, i_acc_q;
  logic upd_q;
  wire signed [31:0] p_term = e_q * $signed({1'b0, kp_q});
  wire signed [31:0] i_term = i_acc_q * $signed({1'b0, ki_q});
  wire signed [16:0] d_diff = {e_q[15], e_q} - {e_prev_q[15], e_prev_q};
  wire signed [33:0] d_term = d_diff * $signed({2'b00, kd_q});
  wire signed [16:0] i_sum = {i_acc_q[15], i_acc_q} + {e_q[15], e_q};
  wire signed [16:0] i_lim = $signed({2'b00, ilim_q});
  wire signed [15:0] i_next = (i_sum > i_lim) ? i_lim[15:0] :
                              (i_sum < -i_lim) ? 16'(-i_lim) :
                              i_sum[15:0];
  wire signed [34:0] pid_sum = 35'(p_term) + 35'(i_term) + 35'(d_term);
  wire signed [34:0] scaled = pid_sum >>> `OUT_SHIFT;
  wire sat_hi = scaled > 35'sh0ff;
  wire sat_lo = scaled < -35'sh0ff;
  wire [7:0] mag_w = sat_hi || sat_lo ? `DRIVE_MAX :
                     scaled[34] ? 8'(-scaled) : scaled[7:0];

  // The error is sampled on the tick; the sum is taken one cycle later.
  logic [7:0] mag_q;
  logic neg_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      e_q <= 16'sh0;
      e_prev_q <= 16'sh0;
      i_acc_q <= 16'sh0;
      upd_q <= 1'b0;
      mag_q <= 8'h00;
      neg_q <= 1'b0;
    end else begin
      upd_q <= tick;
      if (tick) begin
        e_prev_q <= e_q;
        e_q <= err_sat;
      end
      if (upd_q) begin
        i_acc_q <= i_next;
        mag_q <= mag_w;
        neg_q <= scaled[34];
      end
    end
  end

  // PWM carrier; drive into an active limit is suppressed, since that is
  // the end of travel and pushing further could damage the stage.
  logic [7:0] cnt_q;
  logic pwm_q, rev_q, fwd_s_q, rev_s_q, busy_q;
  wire blocked = neg_q ? rev_act : fwd_act;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      pwm_q <= 1'b0;
      rev_q <= 1'b0;
      fwd_s_q <= 1'b0;
      rev_s_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      pwm_q <= (cnt_q < mag_q) && !blocked;
      rev_q <= neg_q;
      fwd_s_q <= fwd_act;
      rev_s_q <= rev_act;
      busy_q <= (st_q == ST_MOVE) || (st_q == ST_HOME);
    end
  end

  assign motor_pwm = pwm_q;
  assign motor_rev = rev_q;
  assign position = pos_q;
  assign fwd_limit = fwd_s_q;
  assign rev_limit = rev_s_q;
  assign busy = busy_q;
  assign homed = homed_q;

  property p_ilim;
    @(posedge ref_clk) disable iff (rst)
      upd_q |=> (i_acc_q <= $signed({1'b0, $past(ilim_q)})) &&
                (i_acc_q >= -$signed({1'b0, $past(ilim_q)}));
  endproperty
  a_ilim: assert property (p_ilim) else $error("integral over limit");

  property p_quad_up;
    @(posedge ref_clk) disable iff (rst)
      q_step && q_up && !home_hit |=> pos_q == $past(pos_q) + 32'sh1;
  endproperty
  a_quad_up: assert property (p_quad_up) else $error("count up missed");

  property p_quad_dn;
    @(posedge ref_clk) disable iff (rst)
      q_step && !q_up && !home_hit |=> pos_q == $past(pos_q) - 32'sh1;
  endproperty
  a_quad_dn: assert property (p_quad_dn) else $error("count down missed");

  property p_home_start;
    @(posedge ref_clk) disable iff (rst)
      hold_hit && can_cmd |=> st_q == ST_HOME ##1 busy;
  endproperty
  a_home_start: assert property (p_home_start) else $error("home not begun");

  property p_hold_restart;
    @(posedge ref_clk) disable iff (rst)
      !both |=> hold_q == '0 && !hold_done_q;
  endproperty
  a_hold_restart: assert property (p_hold_restart) else $error("hold kept");

  property p_goto_top;
    @(posedge ref_clk) disable iff (rst)
      can_cmd && !hold_hit && top_press && mode_q == MODE_GOTO
        |=> goal_q == $signed($past(top_q)) && st_q == ST_MOVE;
  endproperty
  a_goto_top: assert property (p_goto_top) else $error("top goto wrong");

  property p_goto_bot;
    @(posedge ref_clk) disable iff (rst)
      can_cmd && !hold_hit && bot_press && mode_q == MODE_GOTO
        |=> goal_q == $signed($past(bot_q)) && st_q == ST_MOVE;
  endproperty
  a_goto_bot: assert property (p_goto_bot) else $error("bottom goto wrong");

  property p_sat;
    @(posedge ref_clk) disable iff (rst)
      upd_q && sat_hi |=> mag_q == `DRIVE_MAX && !neg_q;
  endproperty
  a_sat: assert property (p_sat) else $error("drive not saturated");

  // With only damping set, a gain of 256 or more turns any change of the
  // error into at least one step of drive, in either direction.
  property p_deriv;
    @(posedge ref_clk) disable iff (rst)
      upd_q && kp_q == 15'h0000 && ki_q == 15'h0000 && kd_q[14:8] != 7'h00
        && e_q != e_prev_q |=> mag_q != 8'h00;
  endproperty
  a_deriv: assert property (p_deriv)
    else $error("no damping");

  property p_boot_load;
    @(posedge ref_clk) disable iff (rst)
      // The sampled reset keeps the attempt at the releasing edge out, since
      // the load happens only on the edge after that.
      st_q == ST_BOOT && !rst |=> kp_q == $past(nv_kp) && st_q == ST_IDLE;
  endproperty
  a_boot_load: assert property (p_boot_load) else $error("boot load");

  property p_limit_block;
    @(posedge ref_clk) disable iff (rst)
      fwd_act && !neg_q |=> !motor_pwm;
  endproperty
  a_limit_block: assert property (p_limit_block) else $error("limit drive");

endmodule : dc_servo_position_loop

// ==== core/servo_map.svh ====
// Scale factors, reset values and timing counts for the DC servo position loop.
`ifndef SERVO_MAP_SVH
`define SERVO_MAP_SVH

// Clock rate of ref_clk in hertz.
`define CLK_HZ 50000000
// Both buttons must be held this long to start a homing move.
`define HOLD_TIME_MS 2000
`define HOLD_CYCLES ((`HOLD_TIME_MS) * ((`CLK_HZ) / 1000))
// Button contact bounce settles within this time.
`define DEB_TIME_MS 10
`define DEB_CYCLES ((`DEB_TIME_MS) * ((`CLK_HZ) / 1000))
// Servo sample period; the profile and the filter update once per period.
`define SAMPLE_TIME_US 20
`define SAMPLE_CYCLES ((`SAMPLE_TIME_US) * ((`CLK_HZ) / 1000000))
// Right shift that scales the filter sum down to the drive range.
`define OUT_SHIFT 8
// Largest drive magnitude and largest 16-bit error.
`define DRIVE_MAX 8'hff
`define ERR_MAX 16'h7fff
// Working configuration after reset, before the retained set is loaded.
`define GAIN_RESET 15'h0000

`endif

// ==== core/servo_pkg.sv ====
// Types shared by the servo position loop.
package servo_pkg;

  // What the front-panel buttons do.
  typedef enum logic {
    MODE_JOG  = 1'b0,
    MODE_GOTO = 1'b1
  } btn_mode_e;

  // How a limit switch behaves on contact.
  typedef enum logic [1:0] {
    LIM_MAKES  = 2'b00,
    LIM_BREAKS = 2'b01,
    LIM_IGNORE = 2'b10
  } lim_cfg_e;

  // Motion sequencer states.
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_IDLE = 2'b01,
    ST_MOVE = 2'b10,
    ST_HOME = 2'b11
  } motion_e;

endpackage : servo_pkg

// ==== test/dc_servo_position_loop_bench.sv ====
// Self-checking bench for the DC servo position loop with a motor model.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %0d want %0d", $time, (g), (e)); end end
module dc_servo_position_loop_bench import servo_pkg::*;;
  localparam int HOLD = 50;
  localparam int DEB = 4;
  localparam int SAMPLE = 8;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic enc_a, enc_b, fwd_lim_in, rev_lim_in;
  logic btn_top = 1'b0;
  logic btn_bot = 1'b0;
  lim_cfg_e fwd_cfg = LIM_MAKES;
  lim_cfg_e rev_cfg = LIM_MAKES;
  logic fwd_pol = 1'b0;
  logic rev_pol = 1'b0;
  logic stage_pol = 1'b0;
  logic home_fwd = 1'b0;
  logic [15:0] vel = 16'h0010;
  logic [14:0] nv_kp = 15'h0100;
  btn_mode_e nv_mode = MODE_GOTO;
  btn_mode_e h_mode = MODE_JOG;
  logic [14:0] h_kp = 15'h0000, h_ki = 15'h0000;
  logic [14:0] h_kd = 15'h0000, h_ilim = 15'h0000;
  logic [31:0] top_pos = 32'h0000_0064;
  logic [31:0] bot_pos = 32'hffff_ffc4;
  logic [31:0] jog_step = 32'h0000_001e;
  logic host_load = 1'b0;
  logic motor_pwm, motor_rev, fwd_limit, rev_limit, busy, homed;
  logic [31:0] position;
  logic [5:0] flags;
  int err_count = 0;
  int compares = 0;
  int exp_pos = 0;
  int cycles = 0;
  int seed, dir;
  int rows [5][5] = '{'{2560, 0, 0, 0, 5}, '{32767, 0, 0, 0, 5},
    '{2560, 0, 0, 0, 55}, '{0, 256, 0, 100, 55}, '{0, 0, 32767, 0, 55}};

  // Clock and hang guard; the run needs well under half the ceiling.
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      final_report();
    end
  end
  assign flags = {motor_pwm, motor_rev, fwd_limit, rev_limit, busy, homed};

  // Shortened hold, settle and sample counts keep the run brief.
  dc_servo_position_loop #(.HOLD_CYCLES(HOLD), .DEB_CYCLES(DEB),
    .SAMPLE_CYCLES(SAMPLE)) uut (.ref_clk(ref_clk), .rst(rst),
    .enc_a(enc_a), .enc_b(enc_b), .fwd_lim_in(fwd_lim_in),
    .rev_lim_in(rev_lim_in), .btn_top(btn_top), .btn_bot(btn_bot),
    .fwd_lim_cfg(fwd_cfg), .rev_lim_cfg(rev_cfg), .fwd_lim_pol(fwd_pol),
    .rev_lim_pol(rev_pol), .home_fwd(home_fwd), .home_vel(vel),
    .jog_vel(vel), .move_vel(vel), .nv_kp(nv_kp), .nv_ki(h_ki),
    .nv_kd(h_kd), .nv_ilim(h_ilim), .nv_mode(nv_mode),
    .nv_top_pos(top_pos), .nv_bot_pos(bot_pos), .nv_jog_step(jog_step),
    .host_load(host_load), .host_kp(h_kp), .host_ki(h_ki), .host_kd(h_kd),
    .host_ilim(h_ilim), .host_mode(h_mode), .host_top_pos(top_pos),
    .host_bot_pos(bot_pos), .host_jog_step(jog_step),
    .motor_pwm(motor_pwm), .motor_rev(motor_rev), .position(position),
    .fwd_limit(fwd_limit), .rev_limit(rev_limit), .busy(busy),
    .homed(homed));

  // The stage is held stalled, so the shaft only moves by hand.
  motor_model motor (.ref_clk(ref_clk), .motor_pwm(motor_pwm),
    .motor_rev(motor_rev), .stall(1'b1), .stage_pol(stage_pol),
    .enc_a(enc_a), .enc_b(enc_b), .fwd_lim_in(fwd_lim_in),
    .rev_lim_in(rev_lim_in));

  // Steady drive of the filter for a given gain set and error.
  function automatic int drive(int kp, int ki, int ilim, int e);
    int acc;
    acc = (e > 0) ? ilim : (e < 0) ? -ilim : 0;
    drive = (kp * e + ki * acc) >>> 8;
    if (drive > 255) drive = 255;
    if (drive < -255) drive = -255;
  endfunction : drive

  task automatic final_report;
    $display("Compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic wait_busy(input logic want, input int limit);
    int n;
    n = 0;
    while (busy !== want && n < limit) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(busy, want)
  endtask : wait_busy

  // One full PWM frame after settling gives the magnitude exactly.
  task automatic duty_check(input int want);
    int n;
    n = 0;
    repeat (120) @(negedge ref_clk);
    repeat (256) begin
      @(negedge ref_clk);
      if (motor_pwm === 1'b1) n++;
    end
    `CHK(n, (want < 0) ? -want : want)
    if (want != 0) `CHK(motor_rev, (want < 0) ? 1'b1 : 1'b0)
  endtask : duty_check

  task automatic step(input int d, input logic chk);
    @(posedge ref_clk);
    motor.nudge(d);
    exp_pos += d;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    if (chk) `CHK(position, 32'(exp_pos))
  endtask : step

  task automatic move_to(input int p);
    while (exp_pos != p) step((p > exp_pos) ? 1 : -1, 1'b1);
  endtask : move_to

  task automatic press(input logic top, input logic bot);
    @(posedge ref_clk);
    btn_top <= top;
    btn_bot <= bot;
    wait_busy(1'b1, 30);
    @(posedge ref_clk);
    btn_top <= 1'b0;
    btn_bot <= 1'b0;
    wait_busy(1'b0, 400);
  endtask : press

  task automatic load(input int kp, input int ki, input int kd, input int il);
    @(posedge ref_clk);
    h_kp <= 15'(kp);
    h_ki <= 15'(ki);
    h_kd <= 15'(kd);
    h_ilim <= 15'(il);
    host_load <= 1'b1;
    @(posedge ref_clk);
    host_load <= 1'b0;
  endtask : load

  // Every switch mode and level against a known contact state.
  task automatic lim_table(input logic ft, input logic rt);
    logic f, r;
    for (int c = 0; c < 3; c++) begin
      for (int p = 0; p < 4; p++) begin
        @(posedge ref_clk);
        fwd_cfg <= lim_cfg_e'(c);
        rev_cfg <= lim_cfg_e'(c);
        fwd_pol <= p[0];
        rev_pol <= p[0];
        stage_pol <= p[1];
        repeat (3) @(negedge ref_clk);
        f = (c != 2) && (((ft ? p[1] : !p[1]) == p[0]) ^ (c == 1));
        r = (c != 2) && (((rt ? p[1] : !p[1]) == p[0]) ^ (c == 1));
        `CHK(fwd_limit, f)
        `CHK(rev_limit, r)
      end
    end
    @(posedge ref_clk);
    fwd_cfg <= LIM_MAKES;
    rev_cfg <= LIM_MAKES;
    {fwd_pol, rev_pol, stage_pol} <= 3'h0;
    repeat (3) @(posedge ref_clk);
  endtask : lim_table

  // Main sequence: reset, encoder, switches, buttons, homing, filter.
  initial begin
    seed = $urandom(50);
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(flags, 6'h00)
    `CHK(position, 32'h0000_0000)
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 30; i++) begin
      dir = ($urandom() & 1) ? 1 : -1;
      if (exp_pos >= 10 || exp_pos <= -10) dir = (exp_pos > 0) ? -1 : 1;
      step(dir, 1'b1);
    end
    lim_table(1'b0, 1'b0);
    press(1'b1, 1'b0);
    duty_check(drive(256, 0, 0, 100 - exp_pos));
    press(1'b0, 1'b1);
    duty_check(drive(256, 0, 0, -60 - exp_pos));
    load(256, 0, 0, 0);
    press(1'b1, 1'b0);
    duty_check(drive(256, 0, 0, -30 - exp_pos));
    @(posedge ref_clk);
    btn_bot <= 1'b1;
    repeat (2) @(posedge ref_clk);
    btn_bot <= 1'b0;
    repeat (10) @(negedge ref_clk);
    `CHK(busy, 1'b0)
    @(posedge ref_clk);
    {btn_top, btn_bot} <= 2'h3;
    repeat (HOLD + DEB + 8) @(posedge ref_clk);
    {btn_top, btn_bot} <= 2'h0;
    @(negedge ref_clk);
    `CHK(busy, 1'b1)
    for (int i = 0; i < 80 && homed !== 1'b1; i++) step(-1, 1'b0);
    `CHK(homed, 1'b1)
    `CHK(position, 32'h0000_0000)
    exp_pos = 0;
    wait_busy(1'b0, 40);
    lim_table(1'b0, 1'b1);
    @(posedge ref_clk);
    btn_bot <= 1'b1;
    repeat (12) @(posedge ref_clk);
    btn_bot <= 1'b0;
    wait_busy(1'b0, 40);
    press(1'b1, 1'b0);
    duty_check(drive(256, 0, 0, 30));
    for (int r = 0; r < 5; r++) begin
      load(rows[r][0], rows[r][1], rows[r][2], rows[r][3]);
      move_to(rows[r][4]);
      duty_check(drive(rows[r][0], rows[r][1], rows[r][3], 30 - exp_pos));
    end
    // One more count with only damping set gives the filter a kick.
    step(1, 1'b1);
    // Forward homing: the stage already sits on the forward switch.
    @(posedge ref_clk);
    home_fwd <= 1'b1;
    {btn_top, btn_bot} <= 2'h3;
    repeat (HOLD + DEB + 8) @(posedge ref_clk);
    {btn_top, btn_bot} <= 2'h0;
    @(negedge ref_clk);
    `CHK(homed, 1'b1)
    `CHK(position, 32'h0000_0000)
    final_report();
  end
endmodule : dc_servo_position_loop_bench

// ==== test/motor_model.sv ====
// Behavioural brushed DC motor with quadrature encoder and two end switches.
`timescale 1ns/10ps
module motor_model #(
  parameter int FWD_END = 20,
  parameter int REV_END = -20,
  parameter int STEP_CYCLES = 512
) (
  // Clock.
  input wire logic ref_clk,
  // Drive from the controller.
  input wire logic motor_pwm,
  input wire logic motor_rev,
  // Stage behaviour.
  input wire logic stall,
  input wire logic stage_pol,
  // Encoder and end switches.
  output logic enc_a,
  output logic enc_b,
  output logic fwd_lim_in,
  output logic rev_lim_in
);
  int shaft = 0;
  int energy = 0;

  // Moves the shaft one count by hand; call it just after a clock edge.
  task automatic nudge(input int dir);
    shaft <= shaft + dir;
  endtask : nudge

  // A free rotor turns one count per STEP_CYCLES driven cycles; a stalled
  // rotor takes the torque without moving, which keeps the error fixed.
  always @(posedge ref_clk) begin
    if (!stall && motor_pwm === 1'b1) begin
      energy <= energy + 1;
      if (energy == STEP_CYCLES - 1) begin
        energy <= 0;
        shaft <= motor_rev ? shaft - 1 : shaft + 1;
      end
    end
  end

  // Gray code of the shaft count, so only one channel changes per count.
  assign enc_a = shaft[1];
  assign enc_b = shaft[1] ^ shaft[0];

  // A switch shows the stage's active level on contact, the other otherwise.
  assign fwd_lim_in = (shaft >= FWD_END) ? stage_pol : !stage_pol;
  assign rev_lim_in = (shaft <= REV_END) ? stage_pol : !stage_pol;
endmodule : motor_model
